// *** hw/mei_core.sv ***
/*
 * metering event interrupt mask block: event flags, enable mask, phase
 * source register, phase order checker, neutral imbalance comparator and
 * an APB slave for all of it.
 * assumes event inputs are one-cycle pulses from logic on sys_clk.
 */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mei_core
   import mei_pkg::*;
#(
   parameter bit HAS_NEUTRAL = 1'b1
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [DATA_W-1:0]   pwdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic [DATA_W-1:0]        prdata,
   // missing crossing events
   input  wire logic                volt_c_timeout,
   input  wire logic [2:0]          curr_timeout,
   // detected crossing events, one bit per phase a..c
   input  wire logic [2:0]          volt_cross,
   input  wire logic [2:0]          curr_cross,
   // rising voltage crossings for the phase order check
   input  wire logic [2:0]          volt_rise,
   // reset completion
   input  wire logic                reset_complete_event,
   // per-phase level events
   input  wire logic [2:0]          dip_phase,
   input  wire logic [2:0]          overcurrent_phase,
   input  wire logic [2:0]          high_voltage_phase,
   // neutral imbalance inputs
   input  wire logic                sample_valid,
   input  wire logic [SAMPLE_W-1:0] phase_current_sum,
   input  wire logic [SAMPLE_W-1:0] neutral_current_sample,
   // peak window ends
   input  wire logic                current_peak_done,
   input  wire logic                voltage_peak_done,
   // interrupt request
   output logic                     irq
);
   typedef enum logic [0:0] {
      MEI_SEQ_IDLE,
      MEI_SEQ_AFTER_A
   } mei_seq_e;

   // registers
   logic [31:0]         event_interrupt_enable_mask_r;
   logic [31:0]         flags_r;
   logic [SAMPLE_W-1:0] mismatch_threshold_r;
   logic [DATA_W-1:0]   prdata_r;
   logic                pslverr_r;
   mei_seq_e            seq_r;
   mei_seq_e            seq_nxt;

   // bus decode
   logic                setup;
   logic                wr_acc;
   logic                hit_mask;
   logic                hit_flags;
   logic                hit_phsrc;
   logic                hit_thresh;
   logic                mapped;
   logic [31:0]         flag_clr;

   // event vectors
   logic [31:0]         flag_set;
   logic                seq_fault;
   logic                imbalance;
   logic [SAMPLE_W-1:0] abs_sum;
   logic [SAMPLE_W-1:0] abs_neut;
   logic [SAMPLE_W-1:0] mag_diff;

   // phase source instances
   logic                dip_flag;
   logic                oc_flag;
   logic                hv_flag;
   logic [2:0]          dip_src;
   logic [2:0]          oc_src;
   logic [2:0]          hv_src;
   logic [31:0]         phsrc;
   logic [31:0]         flags_all;
   logic [31:0]         mask_eff;

   // ---------------------------------------------------------------- bus

   assign setup      = psel & ~penable;
   assign wr_acc     = psel & penable & pwrite;
   assign hit_mask   = (paddr == OFS_MASK);
   assign hit_flags  = (paddr == OFS_FLAGS);
   assign hit_phsrc  = (paddr == OFS_PHSRC);
   assign hit_thresh = (paddr == OFS_THRESH);
   assign mapped     = hit_mask | hit_flags | hit_phsrc | hit_thresh;

   // zero wait states: read data is fetched in the setup cycle
   assign pready     = 1'b1;
   assign prdata     = prdata_r;
   assign pslverr    = pslverr_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup) begin
         if (pwrite) begin
            prdata_r <= 32'h0000_0000;
         end else if (hit_mask) begin
            prdata_r <= event_interrupt_enable_mask_r;
         end else if (hit_flags) begin
            prdata_r <= flags_all;
         end else if (hit_phsrc) begin
            prdata_r <= phsrc;
         end else if (hit_thresh) begin
            prdata_r <= {{(DATA_W-SAMPLE_W){1'b0}}, mismatch_threshold_r};
         end else begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pslverr_r <= 1'b0;
      end else if (setup) begin
         pslverr_r <= ~mapped;
      end
   end

   // only defined bits store; reserved bits stay zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_interrupt_enable_mask_r <= MASK_RESET;
      end else if (wr_acc && hit_mask) begin
         event_interrupt_enable_mask_r <= pwdata & MASK_DEFINED;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mismatch_threshold_r <= THRESH_RESET;
      end else if (wr_acc && hit_thresh) begin
         mismatch_threshold_r <= pwdata[SAMPLE_W-1:0];
      end
   end

   // flags clear by writing one
   assign flag_clr = (wr_acc && hit_flags) ? pwdata : 32'h0000_0000;

   // ---------------------------------------------------------------- events

   // phase order: after a rising A, a rising C before the next rising B is a fault
   always_comb begin
      seq_nxt   = seq_r;
      seq_fault = 1'b0;
      unique case (seq_r)
         MEI_SEQ_IDLE: begin
            if (volt_rise[0]) begin
               seq_nxt = MEI_SEQ_AFTER_A;
            end
         end
         MEI_SEQ_AFTER_A: begin
            if (volt_rise[2] && !volt_rise[1]) begin
               seq_fault = 1'b1;
               seq_nxt   = volt_rise[0] ? MEI_SEQ_AFTER_A : MEI_SEQ_IDLE;
            end else if (volt_rise[1]) begin
               seq_nxt   = volt_rise[0] ? MEI_SEQ_AFTER_A : MEI_SEQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_r <= MEI_SEQ_IDLE;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   // neutral imbalance: ||sum| - |neutral|| against the threshold
   assign abs_sum  = phase_current_sum[SAMPLE_W-1] ? (~phase_current_sum + 1'b1) : phase_current_sum;
   assign abs_neut = neutral_current_sample[SAMPLE_W-1] ? (~neutral_current_sample + 1'b1)
                                                        : neutral_current_sample;
   assign mag_diff = (abs_sum >= abs_neut) ? (abs_sum - abs_neut) : (abs_neut - abs_sum);
   // variants without a neutral channel never raise it
   assign imbalance = HAS_NEUTRAL & sample_valid & (mag_diff > mismatch_threshold_r);

   always_comb begin
      flag_set                          = 32'h0000_0000;
      flag_set[BIT_TOVC]                = volt_c_timeout;
      flag_set[BIT_TOI_LSB +: 3]        = curr_timeout;
      flag_set[BIT_ZXV_LSB +: 3]        = volt_cross;
      flag_set[BIT_ZXI_LSB +: 3]        = curr_cross;
      flag_set[BIT_RST_END]             = reset_complete_event;
      flag_set[BIT_SEQ]                 = seq_fault;
      flag_set[BIT_MISM]                = imbalance;
      flag_set[BIT_IPK]                 = current_peak_done;
      flag_set[BIT_VPK]                 = voltage_peak_done;
   end

   // a set arriving with its clear wins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= (flags_r & ~flag_clr) | flag_set;
      end
   end

   // the three per-phase events keep their own sources
   mei_phase_src u_dip (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .phase_hit (dip_phase),
      .clr       (flag_clr[BIT_DIP]),
      .flag_r    (dip_flag),
      .src_r     (dip_src)
   );

   mei_phase_src u_oc (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .phase_hit (overcurrent_phase),
      .clr       (flag_clr[BIT_OC]),
      .flag_r    (oc_flag),
      .src_r     (oc_src)
   );

   mei_phase_src u_hv (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .phase_hit (high_voltage_phase),
      .clr       (flag_clr[BIT_HV]),
      .flag_r    (hv_flag),
      .src_r     (hv_src)
   );

   always_comb begin
      phsrc                       = 32'h0000_0000;
      phsrc[SRC_DIP_LSB +: 3]     = dip_src;
      phsrc[SRC_OC_LSB +: 3]      = oc_src;
      phsrc[SRC_HV_LSB +: 3]      = hv_src;
   end

   always_comb begin
      flags_all          = flags_r & MASK_DEFINED;
      flags_all[BIT_DIP] = dip_flag;
      flags_all[BIT_OC]  = oc_flag;
      flags_all[BIT_HV]  = hv_flag;
   end

   // ---------------------------------------------------------------- request

   // bit 15 is dropped from the gate, reset completion is forced instead
   always_comb begin
      mask_eff              = event_interrupt_enable_mask_r & MASK_DEFINED;
      mask_eff[BIT_RST_END] = 1'b1;
      mask_eff[BIT_MISM]    = HAS_NEUTRAL & event_interrupt_enable_mask_r[BIT_MISM];
   end

   assign irq = |(flags_all & mask_eff);
endmodule
`default_nettype wire

// *** hw/mei_pkg.sv ***
/*
 * constants for the metering event interrupt mask block: register offsets,
 * field positions, reset values, bus widths.
 * assumes a single 100 MHz clock and a 32-bit APB register bus.
 */
// How it works
// - mask bits 5..8 gate the missing crossing events of voltage C and currents A, B, C.
// - mask bits 9..11 gate the detected crossing events of voltages A, B, C.
// - mask bits 12..14 gate the detected crossing events of currents A, B, C.
// - the reset-complete event always interrupts and mask bit 15 is storage only.
// - mask bit 16 gates the voltage dip event whose phases show in source bits 14:12.
// - mask bit 17 gates the overcurrent event whose phases show in source bits 5:3.
// - mask bit 18 gates the overvoltage event whose phases show in source bits 11:9.
// - mask bit 19 gates the phase order fault, a rising A crossing next followed by C instead of B.
// - mask bit 20 gates the neutral imbalance event and does nothing on parts without neutral.
// - mask bit 23 gates the end of the current peak window.
// - mask bit 24 gates the end of the voltage peak window.
// - bits 22:21 and 31:25 are reserved zero and every mask bit resets to zero.
// - each dip source bit is set when its phase raised the dip flag at status bit 16.
package mei_pkg;
   localparam int          DATA_W         = 32;
   localparam int          ADDR_W         = 8;
   localparam int          SAMPLE_W       = 28;
   // register byte offsets
   localparam logic [7:0]  OFS_MASK       = 8'h00;
   localparam logic [7:0]  OFS_FLAGS      = 8'h04;
   localparam logic [7:0]  OFS_PHSRC      = 8'h08;
   localparam logic [7:0]  OFS_THRESH     = 8'h0C;
   // mask and flag positions
   localparam int          BIT_TOVC       = 5;
   localparam int          BIT_TOI_LSB    = 6;
   localparam int          BIT_ZXV_LSB    = 9;
   localparam int          BIT_ZXI_LSB    = 12;
   localparam int          BIT_RST_END    = 15;
   localparam int          BIT_DIP        = 16;
   localparam int          BIT_OC         = 17;
   localparam int          BIT_HV         = 18;
   localparam int          BIT_SEQ        = 19;
   localparam int          BIT_MISM       = 20;
   localparam int          BIT_IPK        = 23;
   localparam int          BIT_VPK        = 24;
   // phase source fields
   localparam int          SRC_OC_LSB     = 3;
   localparam int          SRC_HV_LSB     = 9;
   localparam int          SRC_DIP_LSB    = 12;
   // writable / implemented bits and reset values
   localparam logic [31:0] MASK_DEFINED   = 32'h019F_FFE0;
   localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
   localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
   localparam logic [27:0] THRESH_RESET   = 28'h000_0000;
endpackage

// *** hw/mei_phase_src.sv ***
/*
 * one sticky event flag with its three phase source bits.
 * assumes event and phase inputs are single-cycle pulses on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mei_phase_src (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // event side
   input  wire logic [2:0] phase_hit,
   // software clear of the flag
   input  wire logic       clr,
   // state
   output logic            flag_r,
   output logic [2:0]      src_r
);
   logic hit;

   assign hit = |phase_hit;

   // a new hit in the clear cycle survives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else if (hit) begin
         flag_r <= 1'b1;
      end else if (clr) begin
         flag_r <= 1'b0;
      end
   end

   // sources pile up while the flag stands and vanish with it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_r <= 3'h0;
      end else if (clr) begin
         src_r <= phase_hit;
      end else begin
         src_r <= src_r | phase_hit;
      end
   end
endmodule
`default_nettype wire

// *** tb/mei_core_props.sv ***
/* assertions on mei_core: irq gating, mask and source readback.
   assumes binding to mei_core, seeing only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mei_core_props
   import mei_pkg::*;
(
   // clock, reset, bus
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // events and request
   input wire logic        volt_c_timeout,
   input wire logic [2:0]  curr_timeout,
   input wire logic [2:0]  volt_cross,
   input wire logic [2:0]  curr_cross,
   input wire logic [2:0]  volt_rise,
   input wire logic        reset_complete_event,
   input wire logic [2:0]  dip_phase,
   input wire logic [2:0]  overcurrent_phase,
   input wire logic [2:0]  high_voltage_phase,
   input wire logic        sample_valid,
   input wire logic        current_peak_done,
   input wire logic        voltage_peak_done,
   input wire logic        irq
);
   logic        wr_acc;
   logic        any_ev;
   logic [31:0] clr;
   logic [31:0] mask_sh;
   logic [31:0] src_sh;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   assign wr_acc = psel && penable && pwrite;
   assign any_ev = volt_c_timeout | (|curr_timeout) | (|volt_cross) | (|curr_cross) | (|volt_rise)
                   | reset_complete_event | (|dip_phase) | (|overcurrent_phase) | (|high_voltage_phase)
                   | sample_valid | current_peak_done | voltage_peak_done;
   // a source clear only happens when its flag is written with one
   assign clr = (wr_acc && paddr == OFS_FLAGS) ? {17'h0, {3{pwdata[16]}}, {3{pwdata[18]}}, 3'h0,
                {3{pwdata[17]}}, 3'h0} : 32'h0;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_sh <= 32'h0;
      end else if (wr_acc && paddr == OFS_MASK) begin
         mask_sh <= pwdata & MASK_DEFINED;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_sh <= 32'h0;
      end else begin
         src_sh <= (src_sh & ~clr) | {17'h0, dip_phase, high_voltage_phase, 3'h0, overcurrent_phase, 3'h0};
      end
   end
   a_rst_end_irq: assert property (reset_complete_event |=> irq)
      else $error("reset completion did not raise irq");
   a_irq_holds: assert property (irq && !wr_acc |=> irq)
      else $error("irq dropped without a write");
   a_irq_cause: assert property ($rose(irq) |-> $past(any_ev || wr_acc))
      else $error("irq rose without cause");
   a_mask_read: assert property (psel && !penable && !pwrite && paddr == OFS_MASK |=> prdata == mask_sh)
      else $error("mask readback wrong");
   a_src_read: assert property (psel && !penable && !pwrite && paddr == OFS_PHSRC |=> prdata == $past(src_sh))
      else $error("phase source readback wrong");
   a_miss_gated: assert property (!wr_acc && (volt_c_timeout && mask_sh[5] ||
      |(curr_timeout & mask_sh[8:6])) |=> irq) else $error("missing crossing not gated");
   a_vcross_gated: assert property (!wr_acc && |(volt_cross & mask_sh[11:9]) |=> irq)
      else $error("voltage crossing not gated");
   a_icross_gated: assert property (!wr_acc && |(curr_cross & mask_sh[14:12]) |=> irq)
      else $error("current crossing not gated");
   a_level_gated: assert property (!wr_acc && (|dip_phase && mask_sh[16]
      || |overcurrent_phase && mask_sh[17] || |high_voltage_phase && mask_sh[18]) |=> irq)
      else $error("level event not gated");
   a_peak_gated: assert property (!wr_acc && (current_peak_done && mask_sh[23]
      || voltage_peak_done && mask_sh[24]) |=> irq) else $error("peak window not gated");
   c_rst_end: cover property (reset_complete_event);
   c_flag_clear: cover property (wr_acc && paddr == OFS_FLAGS);
   c_irq_fall: cover property ($fell(irq));
endmodule
bind mei_core mei_core_props u_mei_core_props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .volt_c_timeout(volt_c_timeout), .curr_timeout(curr_timeout), .volt_cross(volt_cross),
   .curr_cross(curr_cross), .volt_rise(volt_rise), .reset_complete_event(reset_complete_event),
   .dip_phase(dip_phase), .overcurrent_phase(overcurrent_phase), .high_voltage_phase(high_voltage_phase),
   .sample_valid(sample_valid), .current_peak_done(current_peak_done),
   .voltage_peak_done(voltage_peak_done), .irq(irq));
`default_nettype wire

// *** tb/mei_core_tb.sv ***
/* testbench for mei_core: each event bit pulsed, gated and cleared over apb.
   assumes a zero wait apb slave and one-cycle event pulses. */
`timescale 1ns/1ps
`default_nettype none
module mei_core_tb
   import mei_pkg::*;
;
   logic                sys_clk;
   logic                rst_n;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic                pready;
   logic                pslverr;
   logic                irq;
   logic                err;
   logic [7:0]          paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic [31:0]         q;
   logic [31:0]         ev;
   logic [SAMPLE_W-1:0] sum;
   logic [SAMPLE_W-1:0] neut;
   int                  fail_count = 0;
   int                  checks_done = 0;
   int                  cyc = 0;
   int                  b;
   // each event bit position drives its own input; phase events hit phases a and c
   mei_core u_mei_core (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .volt_c_timeout(ev[5]), .curr_timeout(ev[8:6]), .volt_cross(ev[11:9]), .curr_cross(ev[14:12]),
      .volt_rise({ev[19], 1'b0, ev[21]}), .reset_complete_event(ev[15]),
      .dip_phase({ev[16], 1'b0, ev[16]}), .overcurrent_phase({ev[17], 1'b0, ev[17]}),
      .high_voltage_phase({ev[18], 1'b0, ev[18]}), .sample_valid(ev[20]), .phase_current_sum(sum),
      .neutral_current_sample(neut), .current_peak_done(ev[23]), .voltage_peak_done(ev[24]), .irq(irq));
   always #5 sys_clk = ~sys_clk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // whole run needs about 700 cycles, well under the 5000-cycle limit
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // idle edge after release keeps back to back calls from driving psel twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic ck_irq(input logic e);
      @(negedge sys_clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
      @(posedge sys_clk);
   endtask
   // the order fault needs a rising a crossing before the c one
   task automatic pulse(input int n);
      if (n == 19) begin
         ev <= 32'h0020_0000;
         @(posedge sys_clk);
      end
      ev <= 32'h1 << n;
      @(posedge sys_clk);
      ev <= 32'h0;
      @(posedge sys_clk);
   endtask
   function automatic logic [31:0] src_exp(input int n);
      case (n)
         BIT_DIP: src_exp = 32'h5 << SRC_DIP_LSB;
         BIT_OC:  src_exp = 32'h5 << SRC_OC_LSB;
         BIT_HV:  src_exp = 32'h5 << SRC_HV_LSB;
         default: src_exp = 32'h0;
      endcase
   endfunction
   initial begin
      {sys_clk, rst_n, psel, penable, pwrite, paddr, pwdata, ev} = '0;
      sum = 28'h000_0064;
      neut = 28'hFFF_FFAB;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_MASK, 32'h0);
      chk("mask reset", q, MASK_RESET);
      apb(1'b1, OFS_MASK, 32'hFFFF_FFFF);
      apb(1'b0, OFS_MASK, 32'h0);
      chk("mask rw", q, MASK_DEFINED);
      apb(1'b1, OFS_MASK, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", {q[31:1], err}, 32'h1);
      // difference equal to the threshold must not flag
      apb(1'b1, OFS_THRESH, 32'h0000_000F);
      apb(1'b0, OFS_THRESH, 32'h0);
      chk("threshold", q, 32'h0000_000F);
      pulse(20);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk("imbalance edge", q, 32'h0);
      neut <= 28'hFFF_FFAC;
      for (b = 5; b < 25; b++) begin
         if (b == 21 || b == 22) continue;
         pulse(b);
         ck_irq(b == 15);
         apb(1'b0, OFS_FLAGS, 32'h0);
         chk("flag", q, 32'h1 << b);
         apb(1'b0, OFS_PHSRC, 32'h0);
         chk("source", q, src_exp(b));
         apb(1'b1, OFS_MASK, 32'h1 << b);
         ck_irq(1'b1);
         apb(1'b1, OFS_MASK, MASK_DEFINED ^ (32'h1 << b));
         ck_irq(b == 15);
         apb(1'b1, OFS_FLAGS, 32'h1 << b);
         apb(1'b0, OFS_PHSRC, 32'h0);
         chk("source clear", q, 32'h0);
         ck_irq(1'b0);
         // an event arriving while its gate already stands open
         apb(1'b1, OFS_MASK, 32'h1 << b);
         pulse(b);
         ck_irq(1'b1);
         apb(1'b1, OFS_FLAGS, 32'h1 << b);
         ck_irq(1'b0);
         apb(1'b1, OFS_MASK, 32'h0);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
